// >>> verilog/bbpm_pkg.sv
// constants for the building bus point map: settings, object codes, bit positions
// assumes the protocol layer decodes objects and hands over type, instance and value
//
// Function
// - node address 0..127 from either setting; 128 and above reads as 127
// - link rates 9600, 19200, 38400 selectable from either baud setting
// - rate settings 2400 or 4800 run the link at 9600 instead
// - protocol enabled only when either protocol select equals 5
// - character format fixed at 8 data bits, no parity, one stop bit
// - value objects 0,1,2 map to run command bits 0,1,15
// - value objects 17..23 to bits 2..8, 24 to bit 13, 25 to bit 14
// - status objects 3..8 report drive status bits 0..5
// - status objects 9..16 report drive status bits 6..12 and 15
// - input objects 1..10 copy final input bits 2..8, 11, 13, 14
// - output objects 1..5 map to output bits 0..4, object 6 to bit 8
// - final inputs combine network run command with other command sources
`default_nettype none
package bbpm_pkg;
    localparam logic [7:0] ADDR_MAX = 8'h7f;
    localparam logic [2:0] PROTO_SEL = 3'h5;
    // baud setting codes
    localparam logic [2:0] BAUD_2400 = 3'h0;
    localparam logic [2:0] BAUD_4800 = 3'h1;
    localparam logic [2:0] BAUD_9600 = 3'h2;
    localparam logic [2:0] BAUD_19200 = 3'h3;
    localparam logic [2:0] BAUD_38400 = 3'h4;
    // link rate select encoding
    localparam logic [1:0] RATE_9600 = 2'h0;
    localparam logic [1:0] RATE_19200 = 2'h1;
    localparam logic [1:0] RATE_38400 = 2'h2;
    // character format
    localparam logic [3:0] CHAR_BITS = 4'h8;
    localparam logic [1:0] STOP_BITS = 2'h1;
    localparam logic PARITY_ON = 1'b0;
    // object types
    localparam logic [1:0] OBJ_BV = 2'h0;
    localparam logic [1:0] OBJ_BI = 2'h1;
    localparam logic [1:0] OBJ_BO = 2'h2;
    localparam logic [4:0] BV_FWD = 5'h00;
    localparam logic [4:0] BV_REV = 5'h01;
    localparam logic [4:0] BV_RST = 5'h02;
    localparam logic [4:0] BV_STAT_LO = 5'h03;
    localparam logic [4:0] BV_STAT_HI = 5'h10;
    localparam logic [4:0] BV_DI_LO = 5'h11;
    localparam logic [4:0] BV_DI_HI = 5'h17;
    localparam logic [4:0] BV_XF = 5'h18;
    localparam logic [4:0] BV_XR = 5'h19;
    localparam logic [4:0] BI_LO = 5'h01;
    localparam logic [4:0] BI_HI = 5'h0a;
    localparam logic [4:0] BO_LO = 5'h01;
    localparam logic [4:0] BO_RLY = 5'h06;
    // bit positions
    localparam int RUN_FWD_BIT = 0;
    localparam int RUN_REV_BIT = 1;
    localparam int RUN_DI_BIT = 2;
    localparam int RUN_XF_BIT = 13;
    localparam int RUN_XR_BIT = 14;
    localparam int RUN_RST_BIT = 15;
    localparam int STAT_HI_BIT = 12;
    localparam int STAT_BUSY_BIT = 15;
    localparam int FIN_EN_BIT = 11;
    localparam int OUT_RLY_BIT = 8;
    localparam logic [15:0] RUN_RESET = 16'h0000;
    localparam logic [15:0] OUT_RESET = 16'h0000;
endpackage
`default_nettype wire

// >>> verilog/bbpm_point_map.sv
// point map between network binary objects and the drive command and status words
// assumes a protocol layer presents one decoded object access per strobe
// assumes settings and drive words are levels synchronous to clk
// link setup outputs follow the selected settings one edge later
`default_nettype none
module bbpm_point_map
    import bbpm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] nodeAddressSettingA,
    input wire logic [7:0] nodeAddressSettingB,
    input wire logic useSettingB,
    input wire logic [2:0] baudSettingA,
    input wire logic [2:0] baudSettingB,
    input wire logic [2:0] protocolSelectA,
    input wire logic [2:0] protocolSelectB,
    input wire logic objStrobe,
    input wire logic objWrite,
    input wire logic [1:0] objType,
    input wire logic [4:0] objInstance,
    input wire logic objValue,
    input wire logic [15:0] driveStatusIn,
    input wire logic [15:0] terminalInputs,
    output logic [6:0] nodeAddress,
    output logic [1:0] linkRate,
    output logic protocolEnable,
    output logic [3:0] charBits,
    output logic parityEnable,
    output logic [1:0] stopBits,
    output logic [15:0] runCommandWord,
    output logic [15:0] outputCommandWord,
    output logic [15:0] driveStatusWord,
    output logic [15:0] finalInputWord,
    output logic ackValid,
    output logic ackNak,
    output logic ackData
);
    typedef struct packed {
        logic [6:0] addr;
        logic [1:0] rate;
        logic en;
        logic [3:0] chr;
        logic par;
        logic [1:0] stp;
        logic [15:0] run;
        logic [15:0] outw;
        logic [15:0] stat;
        logic [15:0] fin;
        logic ackV;
        logic ackN;
        logic ackD;
    } bbpm_state_t;

    // word that an object instance names
    typedef enum logic [1:0] {
        TGT_RUN = 2'h0,
        TGT_STAT = 2'h1,
        TGT_FIN = 2'h2,
        TGT_OUT = 2'h3
    } bbpm_tgt_t;

    bbpm_state_t state_r;
    bbpm_state_t state_nxt;

    logic [7:0] addrSel;
    logic [2:0] baudSel;
    logic [4:0] idx;
    bbpm_tgt_t tgt;
    logic hit;
    logic ro;
    logic ok;
    logic rd;

    always_comb begin
        state_nxt = state_r;
        addrSel = useSettingB ? nodeAddressSettingB : nodeAddressSettingA;
        baudSel = useSettingB ? baudSettingB : baudSettingA;
        idx = 5'h00;
        tgt = TGT_RUN;
        hit = 1'b0;
        ro = 1'b0;
        ok = 1'b0;
        rd = 1'b0;

        // link setup: address and rate from the selected setting set, enable from either protocol select
        if (addrSel > ADDR_MAX) state_nxt.addr = ADDR_MAX[6:0];
        else state_nxt.addr = addrSel[6:0];
        unique case (baudSel)
            BAUD_2400: state_nxt.rate = RATE_9600;
            BAUD_4800: state_nxt.rate = RATE_9600;
            BAUD_9600: state_nxt.rate = RATE_9600;
            BAUD_19200: state_nxt.rate = RATE_19200;
            BAUD_38400: state_nxt.rate = RATE_38400;
            default: state_nxt.rate = RATE_9600;
        endcase
        state_nxt.en = (protocolSelectA == PROTO_SEL)
            || (protocolSelectB == PROTO_SEL);
        state_nxt.chr = CHAR_BITS;
        state_nxt.par = PARITY_ON;
        state_nxt.stp = STOP_BITS;

        // status and final inputs refresh every cycle
        state_nxt.stat = driveStatusIn;
        state_nxt.fin = terminalInputs | state_r.run;
        // run, reverse and reset bits are not terminal commands
        state_nxt.fin[RUN_FWD_BIT] = 1'b0;
        state_nxt.fin[RUN_REV_BIT] = 1'b0;
        state_nxt.fin[RUN_RST_BIT] = 1'b0;
        state_nxt.ackV = 1'b0;

        // lookup: target word, bit and access kind of the object
        unique case (objType)
            OBJ_BV: begin
                if (objInstance == BV_FWD) begin
                    hit = 1'b1;
                    idx = 5'(RUN_FWD_BIT);
                end else if (objInstance == BV_REV) begin
                    hit = 1'b1;
                    idx = 5'(RUN_REV_BIT);
                end else if (objInstance == BV_RST) begin
                    hit = 1'b1;
                    idx = 5'(RUN_RST_BIT);
                end else if (objInstance >= BV_STAT_LO && objInstance < BV_STAT_HI) begin
                    hit = 1'b1;
                    ro = 1'b1;
                    tgt = TGT_STAT;
                    idx = objInstance - BV_STAT_LO;
                end else if (objInstance == BV_STAT_HI) begin
                    hit = 1'b1;
                    ro = 1'b1;
                    tgt = TGT_STAT;
                    idx = 5'(STAT_BUSY_BIT);
                end else if (objInstance >= BV_DI_LO && objInstance <= BV_DI_HI) begin
                    hit = 1'b1;
                    idx = objInstance - BV_DI_LO + 5'(RUN_DI_BIT);
                end else if (objInstance == BV_XF) begin
                    hit = 1'b1;
                    idx = 5'(RUN_XF_BIT);
                end else if (objInstance == BV_XR) begin
                    hit = 1'b1;
                    idx = 5'(RUN_XR_BIT);
                end
            end
            OBJ_BI: begin
                ro = 1'b1;
                tgt = TGT_FIN;
                if (objInstance >= BI_LO && objInstance <= 5'h07) begin
                    hit = 1'b1;
                    idx = objInstance + 5'h01;
                end else if (objInstance == 5'h08) begin
                    hit = 1'b1;
                    idx = 5'(FIN_EN_BIT);
                end else if (objInstance > 5'h08 && objInstance <= BI_HI) begin
                    hit = 1'b1;
                    idx = objInstance + 5'h04;
                end
            end
            OBJ_BO: begin
                tgt = TGT_OUT;
                if (objInstance >= BO_LO && objInstance < BO_RLY) begin
                    hit = 1'b1;
                    idx = objInstance - BO_LO;
                end else if (objInstance == BO_RLY) begin
                    hit = 1'b1;
                    idx = 5'(OUT_RLY_BIT);
                end
            end
            default: hit = 1'b0;
        endcase

        // read bit is the value before this access writes
        unique case (tgt)
            TGT_RUN: rd = state_r.run[idx[3:0]];
            TGT_STAT: rd = state_r.stat[idx[3:0]];
            TGT_FIN: rd = state_r.fin[idx[3:0]];
            TGT_OUT: rd = state_r.outw[idx[3:0]];
        endcase
        ok = hit && !(ro && objWrite);

        if (objStrobe && state_r.en) begin
            if (ok && objWrite && tgt == TGT_RUN) state_nxt.run[idx[3:0]] = objValue;
            if (ok && objWrite && tgt == TGT_OUT) state_nxt.outw[idx[3:0]] = objValue;
            state_nxt.ackV = 1'b1;
            state_nxt.ackN = !ok;
            state_nxt.ackD = rd && hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= '0;
            state_r.run <= RUN_RESET;
            state_r.outw <= OUT_RESET;
            // character format is fixed from reset onward
            state_r.chr <= CHAR_BITS;
            state_r.par <= PARITY_ON;
            state_r.stp <= STOP_BITS;
        end else begin
            state_r <= state_nxt;
        end
    end

    // every output is a register of the state
    assign nodeAddress = state_r.addr;
    assign linkRate = state_r.rate;
    assign protocolEnable = state_r.en;
    assign charBits = state_r.chr;
    assign parityEnable = state_r.par;
    assign stopBits = state_r.stp;
    assign runCommandWord = state_r.run;
    assign outputCommandWord = state_r.outw;
    assign driveStatusWord = state_r.stat;
    assign finalInputWord = state_r.fin;
    assign ackValid = state_r.ackV;
    assign ackNak = state_r.ackN;
    assign ackData = state_r.ackD;
endmodule
`default_nettype wire

// >>> dv/bbpm_net_master.sv
// network master model: one decoded object access at a time
// assumes the point map answers on the taking edge, half a cycle before the master samples
`default_nettype none
module bbpm_net_master (
    input wire logic clk,
    input wire logic ackValid,
    input wire logic ackNak,
    input wire logic ackData,
    output logic objStrobe,
    output logic objWrite,
    output logic objValue,
    output logic [1:0] objType,
    output logic [4:0] objInstance
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {objStrobe, objWrite, objType, objInstance, objValue} = '0;
    task automatic access(input logic [8:0] req, output logic [2:0] ans);
        @(negedge clk) {objStrobe, objWrite, objType, objInstance, objValue} <= {1'b1, req};
        @(negedge clk) ans = {ackValid, ackNak, ackData};
        {objStrobe, objValue} <= {1'b0, ~req[0]};
    endtask
endmodule
`default_nettype wire

// >>> dv/bbpm_point_map_chk.sv
// checker on the point map ports: settings, command words and answers
// assumes it is bound to every point map instance
`default_nettype none
module bbpm_point_map_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic useSettingB,
    input wire logic objStrobe,
    input wire logic objWrite,
    input wire logic objValue,
    input wire logic protocolEnable,
    input wire logic ackValid,
    input wire logic ackNak,
    input wire logic [7:0] nodeAddressSettingA,
    input wire logic [2:0] baudSettingA,
    input wire logic [2:0] protocolSelectA,
    input wire logic [2:0] protocolSelectB,
    input wire logic [1:0] objType,
    input wire logic [1:0] linkRate,
    input wire logic [4:0] objInstance,
    input wire logic [6:0] nodeAddress,
    input wire logic [15:0] driveStatusIn,
    input wire logic [15:0] terminalInputs,
    input wire logic [15:0] runCommandWord,
    input wire logic [15:0] outputCommandWord,
    input wire logic [15:0] driveStatusWord,
    input wire logic [15:0] finalInputWord
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_addr_clamp: assert property ($past(rstn && !useSettingB && nodeAddressSettingA[7])
        |-> nodeAddress == 7'h7f) else $error("address not clamped");
    a_rate_coerce: assert property ($past(rstn && !useSettingB && baudSettingA <= 3'h2)
        |-> linkRate == 2'h0) else $error("rate not 9600");
    a_proto_enable: assert property ($past(rstn) |-> protocolEnable ==
        $past(protocolSelectA == 3'h5 || protocolSelectB == 3'h5)) else $error("enable wrong");
    a_status_copy: assert property ($past(rstn) |-> driveStatusWord == $past(driveStatusIn))
        else $error("status copy wrong");
    a_final_merge: assert property ($past(rstn) |-> finalInputWord ==
        ($past(terminalInputs | runCommandWord) & 16'h7ffc)) else $error("final input wrong");
    a_ro_refuse: assert property (objStrobe && protocolEnable && objWrite && objType == 2'h1
        |=> ackNak && $stable(runCommandWord) && $stable(outputCommandWord)) else $error("ro");
    a_fwd_bit: assert property (objStrobe && protocolEnable && objWrite && objType == 2'h0
        && objInstance == 5'h0 |=> runCommandWord == {$past(runCommandWord[15:1]), $past(objValue)})
        else $error("forward bit wrong");
    a_relay_bit: assert property (objStrobe && protocolEnable && objWrite && objType == 2'h2
        && objInstance == 5'h6 |=> outputCommandWord == {$past(outputCommandWord[15:9]),
        $past(objValue), $past(outputCommandWord[7:0])}) else $error("relay bit wrong");
    c_refused: cover property (ackValid && ackNak);
    c_ignored: cover property (objStrobe && !protocolEnable);
    c_clamped: cover property (nodeAddress == 7'h7f);
endmodule
bind bbpm_point_map bbpm_point_map_chk chk (.*);
`default_nettype wire

// >>> dv/bbpm_point_map_tb.sv
// bench for the point map: settings, command bits, status reads, refusals
// assumes the bound checker and the network master model
`default_nettype none
module bbpm_point_map_tb import bbpm_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, useSettingB, objStrobe, objWrite, objValue, protocolEnable, parityEnable;
    logic ackValid, ackNak, ackData;
    logic [7:0] nodeAddressSettingA, nodeAddressSettingB;
    logic [2:0] baudSettingA, baudSettingB, protocolSelectA, protocolSelectB, ans;
    logic [1:0] objType, linkRate, stopBits;
    logic [4:0] objInstance;
    logic [6:0] nodeAddress;
    logic [3:0] charBits;
    logic [15:0] driveStatusIn, terminalInputs, runCommandWord, outputCommandWord;
    logic [15:0] driveStatusWord, finalInputWord;
    int errors = 0, checked = 0;
    bbpm_point_map dut (.*);
    bbpm_net_master mst (.*);
    always #5 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        errors += int'(s !== e);
        if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    endtask
    task automatic wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_settings;
        for (int b = 0; b < 8; b++) begin
            baudSettingB = 3'(b);
            repeat (2) @(negedge clk);
            chk("rate", 16'(linkRate), (b > 2 && b < 5) ? 16'(b - 2) : 16'h0);
        end
        chk("setup", {nodeAddress, 1'b0, charBits, stopBits, parityEnable, 1'b0}, 16'h5484);
        $display("settings done");
    endtask
    task automatic t_enable;
        {useSettingB, protocolSelectA} = 4'h0;
        repeat (2) @(negedge clk);
        chk("clamp", {nodeAddress, 7'h0, linkRate}, 16'hfe00);
        mst.access({1'b1, OBJ_BV, BV_FWD, 1'b1}, ans);
        chk("idle", 16'(ans), 16'h0);
        protocolSelectB = 3'h5;
        repeat (2) @(negedge clk);
        chk("enable", {runCommandWord[14:0], protocolEnable}, 16'h1);
        $display("enable done");
    endtask
    task automatic t_points;
        logic [15:0] want = 16'h0;
        logic [15:0] fin;
        for (int k = 0; k < 12; k++) begin
            want[k == 2 ? 15 : k < 2 ? k : k < 10 ? k - 1 : k + 3] = 1'b1;
            mst.access({1'b1, OBJ_BV, k < 3 ? 5'(k) : 5'(k + 14), 1'b1}, ans);
            chk("run", runCommandWord, want);
            @(negedge clk);
            chk("final", finalInputWord, (want | terminalInputs) & 16'h7ffc);
        end
        mst.access({1'b1, OBJ_BV, BV_FWD, 1'b0}, ans);
        chk("clear", runCommandWord, want ^ 16'h0001);
        mst.access({1'b1, OBJ_BV, BV_FWD, 1'b1}, ans);
        chk("old bit", 16'(ans), 16'h4);
        mst.access({1'b0, OBJ_BV, BV_RST, 1'b0}, ans);
        chk("run read", 16'(ans), 16'h5);
        for (int i = 1; i < 7; i++) begin
            mst.access({1'b1, OBJ_BO, 5'(i), 1'b1}, ans);
            chk("out", outputCommandWord, i < 6 ? 16'((1 << i) - 1) : 16'h011f);
        end
        mst.access({1'b0, OBJ_BO, BO_RLY, 1'b0}, ans);
        chk("out read", 16'(ans), 16'h5);
        fin = (want | terminalInputs) & 16'h7ffc;
        for (int i = 1; i < 11; i++) begin
            mst.access({1'b0, OBJ_BI, 5'(i), 1'b0}, ans);
            chk("input", 16'(ans), {15'h2, fin[i < 8 ? i + 1 : i == 8 ? 11 : i + 4]});
        end
        $display("points done");
    endtask
    task automatic t_refuse;
        logic [6:0] req [7] = '{7'h05, 7'h10, 7'h21, 7'h2a, 7'h1a, 7'h60, 7'h47};
        driveStatusIn = 16'h9a5c;
        for (int k = 0; k < 7; k++) begin
            mst.access({1'b1, req[k], 1'b0}, ans);
            chk("refuse", {ans[2:1], runCommandWord[13:0]}, 16'he1ff);
            chk("kept", outputCommandWord ^ driveStatusWord, 16'h9b43);
        end
        for (int i = 3; i < 17; i++) begin
            mst.access({1'b0, OBJ_BV, 5'(i), 1'b0}, ans);
            chk("status", 16'(ans), {14'h2, driveStatusIn[i < 16 ? i - 3 : 15]});
        end
        $display("refusals done");
    endtask
    initial begin
        {clk, rstn, protocolSelectB, baudSettingB} = '0;
        useSettingB = 1'b1;
        {nodeAddressSettingA, nodeAddressSettingB} = 16'h802a;
        {baudSettingA, protocolSelectA} = 6'h0d;
        {driveStatusIn, terminalInputs} = 32'h0000_0848;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        t_settings;
        t_enable;
        t_points;
        t_refuse;
        wrap_up;
    end
endmodule
`default_nettype wire
